// ### src/scev_pkg.sv
// Constants shared by the socket status-change event logic.
// Behaviour
// [R1] Power-cycle flag, bit 3, sets whenever the power-cycle state changes.
// [R2] Flag bit 2 follows detect-two changes, flag bit 1 detect-one changes.
// [R3] For a CardBus card, the card-status flag sets only on a rising edge.
// [R4] For a 16-bit card, the card-status flag sets on both edges.
// [R5] Writing 1 to a flag clears it; writing 0 leaves it alone.
// [R6] Writing 1 to a force-event bit sets the matching flag.
// [R7] A host bus reset clears every event flag; the code does so only while pme_enable is off.
// [R8] Leaving card reset re-sets flags whose status is still asserted; the code re-sets only bits 2:0, not power-cycle bit 3.
// [R9] Any set flag with its mask enabled raises the status-change interrupt.
// [R10] Software clears all flags before enabling interrupts, avoiding stale interrupts.
// [R11] Masks only gate the interrupt; flags still set whatever the mask.
// [R12] Mask bit 3 gates power-cycle events: 0 suppresses, 1 enables.
// [R13] Detect mask field bits 2:1: 00 suppresses, 11 enables, 01/10 undefined.
// [R14] Mask bit 0 gates card-status events: 0 suppresses, 1 enables.
// [R15] Bits 31:4 of flags and masks read zero and ignore writes.
// [R16] Flags decode at offset 00h, masks at offset 04h.
// [R17] With wake signalling on, flags and masks survive bus reset; else either clears.
// [R18] Interrupt is OR of flag AND mask; detect counts only with field 11.
package scev_pkg;

    // ****************************************************************
    // Register map.
    // ****************************************************************
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 32;
    localparam int          NUM_EVENTS       = 4;
    localparam logic [7:0]  OFS_CHANGE_FLAGS = 8'h00;
    localparam logic [7:0]  OFS_CHANGE_ENABL = 8'h04;
    localparam logic [7:0]  OFS_FORCE_EVENT  = 8'h0c;

    // ****************************************************************
    // Field positions, shared by flags, enables and force bits.
    // ****************************************************************
    localparam int          BIT_POWER_CYCLE  = 3;
    localparam int          BIT_DETECT_TWO   = 2;
    localparam int          BIT_DETECT_ONE   = 1;
    localparam int          BIT_CARD_STATUS  = 0;
    localparam logic [1:0]  DETECT_FIELD_ON  = 2'h3;

    // ****************************************************************
    // Reset values.
    // ****************************************************************
    localparam logic [3:0]  FLAGS_RESET      = 4'h0;
    localparam logic [3:0]  ENABLES_RESET    = 4'h0;
    localparam logic [31:0] RDATA_RESET      = 32'h0000_0000;

endpackage

// ### src/scev_edge_cell.sv
// Change detector for one socket status level.
`timescale 1ns/100ps
module scev_edge_cell (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic level_in,
    input  wire logic both_edges,
    output logic      change_pulse
);

    logic prev_reg;
    logic primed_reg;

    // Hold the previous level; the primed flag keeps the first sample after
    // reset from being mistaken for a change.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prev_reg   <= 1'b0;
            primed_reg <= 1'b0;
        end else begin
            prev_reg   <= level_in;
            primed_reg <= 1'b1;
        end
    end

    // Rising edges always count; falling edges only when both are asked for.
    always_comb begin
        change_pulse = primed_reg & ((level_in & ~prev_reg) | (both_edges & ~level_in & prev_reg));
    end

endmodule

// ### src/scev_flag_cell.sv
// One sticky event flag with set, write-one clear and context clear.
`timescale 1ns/100ps
module scev_flag_cell (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic ctx_clear,
    input  wire logic set_in,
    input  wire logic clear_in,
    output logic      flag_out
);

    logic flag_reg;
    logic flag_next;

    // A set in the same cycle as a software clear wins, so no event is lost.
    always_comb begin
        flag_next = flag_reg;
        if (ctx_clear) begin
            flag_next = 1'b0;
        end else if (set_in) begin
            flag_next = 1'b1;
        end else if (clear_in) begin
            flag_next = 1'b0;
        end
    end

    // Flag storage.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag_out = flag_reg;

endmodule

// ### src/scev_socket_events.sv
// Status-change event flags, enables and interrupt request for one socket.
`timescale 1ns/100ps
module scev_socket_events (
    input  wire logic                        clock,
    input  wire logic                        nrst,
    input  wire logic                        bus_reset_in,
    input  wire logic                        global_reset_in,
    input  wire logic                        pme_enable,
    input  wire logic [scev_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic                        reg_write,
    input  wire logic [scev_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_read,
    output logic      [scev_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                        power_cycle_state,
    input  wire logic                        detect_two_state,
    input  wire logic                        detect_one_state,
    input  wire logic                        card_status_state,
    input  wire logic                        cardbus_card,
    input  wire logic                        card_reset_active,
    output logic                             status_change_interrupt
);
    import scev_pkg::*;

    // ****************************************************************
    // Declarations.
    // ****************************************************************
    logic [NUM_EVENTS-1:0] state_vec;
    logic [NUM_EVENTS-1:0] both_vec;
    logic [NUM_EVENTS-1:0] change_vec;
    logic [NUM_EVENTS-1:0] rearm_vec;
    logic [NUM_EVENTS-1:0] force_vec;
    logic [NUM_EVENTS-1:0] set_vec;
    logic [NUM_EVENTS-1:0] clear_vec;
    logic [NUM_EVENTS-1:0] flag_vec;
    logic [NUM_EVENTS-1:0] enable_reg;
    logic [NUM_EVENTS-1:0] enable_next;
    logic                  card_reset_prev_reg;
    logic                  leaving_reset;
    logic                  ctx_clear;
    logic                  hit_flags;
    logic                  hit_enables;
    logic                  hit_force;
    logic                  detect_armed;
    logic                  irq_next;
    logic                  irq_reg;
    logic [DATA_W-1:0]     rdata_next;
    logic [DATA_W-1:0]     rdata_reg;

    // ****************************************************************
    // Address decode.
    // ****************************************************************

    // Each register takes one full word; other offsets are not decoded.
    always_comb begin
        hit_flags   = (reg_addr == OFS_CHANGE_FLAGS);  // see [R16]
        hit_enables = (reg_addr == OFS_CHANGE_ENABL);  // see [R16]
        hit_force   = (reg_addr == OFS_FORCE_EVENT);
    end

    // ****************************************************************
    // Context reset.
    // ****************************************************************

    // The global reset always clears the context. A bus reset clears it only
    // while wake signalling is off, so a sleeping host keeps its pending events.
    always_comb begin
        ctx_clear = global_reset_in | (bus_reset_in & ~pme_enable);  // see [R17] see [R7]
    end

    // ****************************************************************
    // Change detection.
    // ****************************************************************

    // Gather the status levels in flag order.
    always_comb begin
        state_vec                  = '0;
        state_vec[BIT_POWER_CYCLE] = power_cycle_state;
        state_vec[BIT_DETECT_TWO]  = detect_two_state;
        state_vec[BIT_DETECT_ONE]  = detect_one_state;
        state_vec[BIT_CARD_STATUS] = card_status_state;
    end

    // Every level reports both edges except card status on a CardBus card,
    // where only the rising edge is a status change.
    always_comb begin
        both_vec                  = '1;                // see [R1] see [R2]
        both_vec[BIT_CARD_STATUS] = ~cardbus_card;     // see [R3] see [R4]
    end

    // One change detector and one sticky flag per event.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVENTS; gi = gi + 1) begin : g_event
            scev_edge_cell u_edge (
                .clock        (clock),
                .nrst         (nrst),
                .level_in     (state_vec[gi]),
                .both_edges   (both_vec[gi]),
                .change_pulse (change_vec[gi])
            );
            scev_flag_cell u_flag (
                .clock        (clock),
                .nrst         (nrst),
                .ctx_clear    (ctx_clear),
                .set_in       (set_vec[gi]),
                .clear_in     (clear_vec[gi]),
                .flag_out     (flag_vec[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Card reset release.
    // ****************************************************************

    // Remember the card reset level to find its release.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            card_reset_prev_reg <= 1'b0;
        end else begin
            card_reset_prev_reg <= card_reset_active;
        end
    end

    // A status that is still asserted when the card leaves reset would
    // otherwise go unreported, since no edge follows it.
    always_comb begin
        leaving_reset              = card_reset_prev_reg & ~card_reset_active;
        rearm_vec                  = '0;
        rearm_vec[BIT_DETECT_TWO]  = leaving_reset & detect_two_state;   // see [R8]
        rearm_vec[BIT_DETECT_ONE]  = leaving_reset & detect_one_state;   // see [R8]
        rearm_vec[BIT_CARD_STATUS] = leaving_reset & card_status_state;  // see [R8]
    end

    // ****************************************************************
    // Flag set and clear.
    // ****************************************************************

    // Flags set regardless of the enables; software writes only touch the
    // low bits, so the upper bits of the word have no effect.
    always_comb begin
        force_vec = (reg_write & hit_force) ? reg_wdata[NUM_EVENTS-1:0] : '0;  // see [R6]
        set_vec   = change_vec | rearm_vec | force_vec;                       // see [R11]
        clear_vec = (reg_write & hit_flags) ? reg_wdata[NUM_EVENTS-1:0] : '0;  // see [R5] see [R15]
    end

    // ****************************************************************
    // Interrupt enables.
    // ****************************************************************

    // Enables are plain read/write bits; the reserved detect codes are
    // stored as written and simply do not arm the detect events.
    always_comb begin
        enable_next = enable_reg;
        if (ctx_clear) begin
            enable_next = ENABLES_RESET;                  // see [R17]
        end else if (reg_write & hit_enables) begin
            enable_next = reg_wdata[NUM_EVENTS-1:0];      // see [R15]
        end
    end

    // Enable storage.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            enable_reg <= ENABLES_RESET;
        end else begin
            enable_reg <= enable_next;
        end
    end

    // ****************************************************************
    // Interrupt request.
    // ****************************************************************

    // Stale flags raise the request as soon as their enable is set, which is
    // why the host must clear the flags first.
    always_comb begin
        detect_armed = (enable_reg[BIT_DETECT_TWO:BIT_DETECT_ONE] == DETECT_FIELD_ON);  // see [R13]
        irq_next     = (flag_vec[BIT_POWER_CYCLE] & enable_reg[BIT_POWER_CYCLE])         // see [R12]
                     | ((flag_vec[BIT_DETECT_TWO] | flag_vec[BIT_DETECT_ONE]) & detect_armed)
                     | (flag_vec[BIT_CARD_STATUS] & enable_reg[BIT_CARD_STATUS]);        // see [R14] see [R18]
    end

    // Registered so the request is glitch free toward the host.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;  // see [R9]
        end
    end

    assign status_change_interrupt = irq_reg;

    // ****************************************************************
    // Read path.
    // ****************************************************************

    // Upper bits always read zero; the force register reads as zero too.
    always_comb begin
        rdata_next = '0;
        if (hit_flags) begin
            rdata_next[NUM_EVENTS-1:0] = flag_vec;    // see [R15]
        end else if (hit_enables) begin
            rdata_next[NUM_EVENTS-1:0] = enable_reg;  // see [R15]
        end
    end

    // Read data appears the cycle after the read strobe and then holds.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= RDATA_RESET;
        end else if (reg_read) begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

endmodule

// ### dv/scev_socket_events_properties.sv
// Port-level checks for the socket status-change event block.
`timescale 1ns/100ps
module scev_socket_events_chk (
    input wire logic                        clock,
    input wire logic                        nrst,
    input wire logic                        bus_reset_in,
    input wire logic                        global_reset_in,
    input wire logic                        pme_enable,
    input wire logic [scev_pkg::ADDR_W-1:0] reg_addr,
    input wire logic                        reg_write,
    input wire logic [scev_pkg::DATA_W-1:0] reg_wdata,
    input wire logic                        reg_read,
    input wire logic [scev_pkg::DATA_W-1:0] reg_rdata,
    input wire logic                        cardbus_card,
    input wire logic                        card_status_state,
    input wire logic                        card_reset_active,
    input wire logic                        status_change_interrupt
);
    import scev_pkg::*;
    // ****************************************************************
    // Properties. The request is registered, so a clear shows two edges on.
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    chk_upper_zero: assert property (reg_rdata[31:4] == 28'h0)
        else $error("upper read bits not zero");
    chk_rdata_holds: assert property (!reg_read |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    chk_unmapped_zero: assert property (reg_read && reg_addr != OFS_CHANGE_FLAGS && reg_addr != OFS_CHANGE_ENABL
        |=> reg_rdata == RDATA_RESET)
        else $error("unmapped read not zero");
    chk_global_clears: assert property (global_reset_in |-> ##2 !status_change_interrupt)
        else $error("interrupt after global reset");
    chk_bus_clears: assert property (bus_reset_in && !pme_enable |-> ##2 !status_change_interrupt)
        else $error("interrupt after bus reset");
    chk_mask_off_quiet: assert property (reg_write && reg_addr == OFS_CHANGE_ENABL && reg_wdata[3:0] == 4'h0
        |-> ##2 !status_change_interrupt)
        else $error("interrupt with all enables off");
    // The bench leaves one idle edge between a write and the next read, so the
    // write must survive that edge untouched before the readback is judged.
    chk_enable_readback: assert property ((reg_write && reg_addr == OFS_CHANGE_ENABL && !global_reset_in
        && !(bus_reset_in && !pme_enable)) ##1 (!(reg_write && reg_addr == OFS_CHANGE_ENABL) && !global_reset_in
        && !(bus_reset_in && !pme_enable)) ##1 (reg_read && reg_addr == OFS_CHANGE_ENABL)
        |=> reg_rdata == {28'h0, $past(reg_wdata[3:0], 3)})
        else $error("enable readback wrong");
    chk_quiet_release: assert property ($rose(nrst) |-> !status_change_interrupt && reg_rdata == RDATA_RESET)
        else $error("outputs not idle after reset");
    cover property ($rose(status_change_interrupt));
    cover property (reg_write && reg_addr == OFS_FORCE_EVENT);
    cover property (cardbus_card && $rose(card_status_state));
    cover property ($fell(card_reset_active));
endmodule

bind scev_socket_events scev_socket_events_chk u_chk (.clock(clock), .nrst(nrst), .bus_reset_in(bus_reset_in),
    .global_reset_in(global_reset_in), .pme_enable(pme_enable), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata), .cardbus_card(cardbus_card),
    .card_status_state(card_status_state), .card_reset_active(card_reset_active),
    .status_change_interrupt(status_change_interrupt));

// ### dv/scev_socket_model.sv
// Card socket model that drives the status sense levels.
`timescale 1ns/100ps
module scev_socket_model (
    input  wire logic clock,
    output logic      power_cycle_state,
    output logic      detect_two_state,
    output logic      detect_one_state,
    output logic      card_status_state,
    output logic      cardbus_card,
    output logic      card_reset_active
);
    // ****************************************************************
    // Levels change just after an edge, so the block never samples a moving line.
    // ****************************************************************
    initial begin
        {power_cycle_state, detect_two_state, detect_one_state, card_status_state} = 4'h0;
        cardbus_card = 1'b1;
        card_reset_active = 1'b0;
    end
    task automatic drive(input logic [3:0] lv, input logic cb, input logic crst);
        @(posedge clock);
        {power_cycle_state, detect_two_state, detect_one_state, card_status_state} <= lv;
        cardbus_card <= cb;
        card_reset_active <= crst;
    endtask
endmodule

// ### dv/test_socket_status_change_events.sv
// Self-checking bench for the socket status-change event block.
`timescale 1ns/100ps
module test_socket_status_change_events;
    import scev_pkg::*;
    logic              clock, nrst, bus_reset_in, global_reset_in, pme_enable, reg_write, reg_read;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic              pcs, d2s, d1s, css, cbc, cra, irq;
    int                n_fail, tests_run;

    scev_socket_model sock (.clock(clock), .power_cycle_state(pcs), .detect_two_state(d2s),
        .detect_one_state(d1s), .card_status_state(css), .cardbus_card(cbc), .card_reset_active(cra));
    scev_socket_events dut (.clock(clock), .nrst(nrst), .bus_reset_in(bus_reset_in),
        .global_reset_in(global_reset_in), .pme_enable(pme_enable), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata), .power_cycle_state(pcs),
        .detect_two_state(d2s), .detect_one_state(d1s), .card_status_state(css), .cardbus_card(cbc),
        .card_reset_active(cra), .status_change_interrupt(irq));

    // ****************************************************************
    // Shared tasks.
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    // Data is taken once the read edge has landed, before the next edge.
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        check(what, exp, reg_rdata);
    endtask
    task automatic ev(input logic [3:0] lv, input logic cb, input logic [31:0] exp);
        sock.drive(lv, cb, 1'b0);
        repeat (3) @(posedge clock);
        rd("flags", OFS_CHANGE_FLAGS, exp);
    endtask
    task automatic irq_is(input logic [3:0] en, input logic exp);
        wr(OFS_CHANGE_ENABL, {28'h0, en});
        repeat (2) @(posedge clock);
        #1;
        check("interrupt", {31'h0, exp}, {31'h0, irq});
    endtask
    task automatic pulse(input logic glob);
        @(posedge clock);
        if (glob) global_reset_in <= 1'b1; else bus_reset_in <= 1'b1;
        @(posedge clock);
        global_reset_in <= 1'b0;
        bus_reset_in <= 1'b0;
    endtask
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic t_regs;
        rd("flags", OFS_CHANGE_FLAGS, 32'h0);
        rd("force", OFS_FORCE_EVENT, 32'h0);
        wr(OFS_CHANGE_ENABL, 32'hffff_ffff);
        rd("enables", OFS_CHANGE_ENABL, 32'h0000_000f);
        wr(8'h10, 32'h0000_0000);
        rd("enables", OFS_CHANGE_ENABL, 32'h0000_000f);
        wr(OFS_CHANGE_ENABL, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_detect;
        ev(4'h8, 1'b1, 32'h8);
        wr(OFS_CHANGE_FLAGS, 32'h8);
        ev(4'h0, 1'b1, 32'h8);
        wr(OFS_CHANGE_FLAGS, 32'h8);
        ev(4'h4, 1'b1, 32'h4);
        ev(4'h6, 1'b1, 32'h6);
        wr(OFS_CHANGE_FLAGS, 32'h2);
        rd("flags", OFS_CHANGE_FLAGS, 32'h4);
        ev(4'h0, 1'b1, 32'h6);
        wr(OFS_CHANGE_FLAGS, 32'hf);
        $display("test detect done");
    endtask
    task automatic t_card_status;
        ev(4'h1, 1'b1, 32'h1);
        wr(OFS_CHANGE_FLAGS, 32'h1);
        ev(4'h0, 1'b1, 32'h0);
        ev(4'h1, 1'b0, 32'h1);
        wr(OFS_CHANGE_FLAGS, 32'h1);
        ev(4'h0, 1'b0, 32'h1);
        wr(OFS_CHANGE_FLAGS, 32'hf);
        $display("test card status done");
    endtask
    task automatic t_mask;
        wr(OFS_CHANGE_FLAGS, 32'hf);
        wr(OFS_FORCE_EVENT, 32'hf);
        rd("flags", OFS_CHANGE_FLAGS, 32'hf);
        irq_is(4'h0, 1'b0);
        irq_is(4'h8, 1'b1);
        irq_is(4'h6, 1'b1);
        irq_is(4'h2, 1'b0);
        irq_is(4'h4, 1'b0);
        irq_is(4'h1, 1'b1);
        wr(OFS_CHANGE_FLAGS, 32'he);
        irq_is(4'h8, 1'b0);
        wr(OFS_FORCE_EVENT, 32'h8);
        repeat (2) @(posedge clock);
        #1;
        check("interrupt", 32'h1, {31'h0, irq});
        $display("test mask done");
    endtask
    task automatic t_resets;
        wr(OFS_FORCE_EVENT, 32'hf);
        wr(OFS_CHANGE_ENABL, 32'hf);
        pme_enable <= 1'b1;
        pulse(1'b0);
        rd("flags", OFS_CHANGE_FLAGS, 32'hf);
        rd("enables", OFS_CHANGE_ENABL, 32'hf);
        pme_enable <= 1'b0;
        pulse(1'b0);
        rd("flags", OFS_CHANGE_FLAGS, 32'h0);
        rd("enables", OFS_CHANGE_ENABL, 32'h0);
        wr(OFS_FORCE_EVENT, 32'hf);
        pme_enable <= 1'b1;
        pulse(1'b1);
        rd("flags", OFS_CHANGE_FLAGS, 32'h0);
        $display("test resets done");
    endtask
    task automatic t_rearm;
        sock.drive(4'h3, 1'b1, 1'b1);
        repeat (3) @(posedge clock);
        wr(OFS_CHANGE_FLAGS, 32'hf);
        sock.drive(4'h3, 1'b1, 1'b0);
        repeat (3) @(posedge clock);
        rd("flags", OFS_CHANGE_FLAGS, 32'h3);
        $display("test rearm done");
    endtask

    // ****************************************************************
    // Clock, watchdog and main sequence.
    // ****************************************************************
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // The whole run is under two hundred cycles; a hang is cut well after that.
    initial begin
        repeat (5000) @(posedge clock);
        n_fail++;
        stop_test();
    end
    initial begin
        {nrst, bus_reset_in, global_reset_in, pme_enable, reg_write, reg_read} = 6'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        t_regs();
        t_detect();
        t_card_status();
        t_mask();
        t_resets();
        t_rearm();
        stop_test();
    end
endmodule
